// >>> design/tmr_timer.sv
// 16-bit free-running timer: control, status, compare outputs, irq.
// Assumes an APB3 master on sys_clk; pins arrive asynchronously.
//
// Summary of operation
// - All timer events share one irq, gated by enables and global mask.
// - No compare-one or compare-two flags while PWM runs.
// - Capture irq enable passes capture flags one and two to irq.
// - Compare irq enable passes compare flags one and two to irq.
// - Overflow irq enable passes the overflow flag to irq.
// - Force two drives match level two on output two if enabled.
// - Force one drives match level one on output one if enabled.
// - Compare-two match copies level two; PWM routes it to one, one-pulse drops it.
// - Capture edge one picks falling (0) or rising (1) on input one.
// - Compare-one match copies match level one to output one.
// - Pin one enable also gates output one updates; flag matching continues.
// - Pin two enable also gates output two updates; flag matching continues.
// - One-pulse mode: input one edge starts a pulse of compare one.
// - PWM: compare one sets pulse length, compare two the period.
// - Clock select 00 div4, 01 div2, 10 div8, 11 external pin.
// - External clock chosen without the pin stops counting.
// - Capture edge two picks falling (0) or rising (1) on input two.
// - External clock edge picks falling (0) or rising (1) edges.
// - Capture flag one set on capture or PWM period end; two-step clear.
// - Compare flags set on matches, flag one not in one-pulse; cleared by status then low byte.
// - Overflow flag on wrap; cleared via counter low, never alternate.
// - Capture flag two set on capture two; two-step clear.
// - PWM compare-two event reloads counter with FFFC.
// - One-pulse and PWM both set means PWM only.
//
// The APB slave port and the register offsets were chosen for this implementation.
`include "tmr_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module tmr_timer (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Timer pins
  input  wire logic        capture_in_one,
  input  wire logic        capture_in_two,
  input  wire logic        ext_clock_pin,
  output var  logic        compare_out_one,
  output var  logic        compare_out_one_oe,
  output var  logic        compare_out_two,
  output var  logic        compare_out_two_oe,
  // Interrupt
  output var  logic        timer_irq
);

  // ===================================================================
  // Reset release
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // ===================================================================
  // Pin synchronisers; third stage only feeds edge detection
  logic [2:0] pin_raw;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] sync3_reg;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  assign pin_raw = {ext_clock_pin, capture_in_two, capture_in_one};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          sync3_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
        end
      end
      assign pin_rise[gi] = sync2_reg[gi] & ~sync3_reg[gi];
      assign pin_fall[gi] = ~sync2_reg[gi] & sync3_reg[gi];
    end
  endgenerate

  // ===================================================================
  // Registers
  logic [7:0]  ctrl_one_reg;
  logic [7:0]  ctrl_two_reg;
  logic [7:0]  sys_ctrl_reg;
  logic [4:0]  flags_reg;
  logic [4:0]  armed_reg;
  logic [15:0] cmp1_reg;
  logic [15:0] cmp2_reg;
  logic [15:0] cap1_reg;
  logic [15:0] cap2_reg;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [2:0]  presc_reg;

  // APB phases: one wait state, side effects at the completing edge
  logic        xfer;
  logic        wr_en;
  logic        rd_en;
  logic        addr_hit;
  logic [31:0] rd_mux;
  logic [4:0]  low_access;
  logic        cnt_wr;

  assign xfer  = psel & penable & pready;
  assign wr_en = xfer & pwrite;
  assign rd_en = xfer & ~pwrite;

  // ===================================================================
  // Modes and control fields
  logic                 pwm_on;
  logic                 single_on;
  tmr_pkg::tmr_clk_sel_t clk_sel;
  logic                 tick;
  logic [15:0]          cnt_inc;
  logic                 cap1_edge;
  logic                 cap2_edge;
  logic                 cmp1_hit;
  logic                 cmp2_hit;
  logic                 ovf_hit;
  logic                 ext_edge;
  logic [4:0]           flag_set;
  logic                 irq_pending;

  assign pwm_on    = ctrl_two_reg[`TMR_PWM_BIT];
  assign single_on = ctrl_two_reg[`TMR_SINGLE_BIT] & ~pwm_on;
  assign clk_sel   = tmr_pkg::tmr_clk_sel_t'(
    ctrl_two_reg[`TMR_CLK_SEL_MSB:`TMR_CLK_SEL_LSB]);

  assign ext_edge = ctrl_two_reg[`TMR_EXT_EDGE_BIT] ? pin_rise[2]
                                                    : pin_fall[2];

  always_comb begin
    case (clk_sel)
      tmr_pkg::TMR_CLK_DIV4: tick = (presc_reg[1:0] == `TMR_DIV4_LAST);
      tmr_pkg::TMR_CLK_DIV2: tick = (presc_reg == `TMR_DIV2_LAST) ||
                                    (presc_reg[0] == 1'b1);
      tmr_pkg::TMR_CLK_DIV8: tick = (presc_reg == `TMR_DIV8_LAST);
      tmr_pkg::TMR_CLK_EXT:  tick = ext_edge &
                                    sys_ctrl_reg[`TMR_EXT_AVAIL_BIT];
      default:               tick = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) presc_reg <= 3'h0;
    else        presc_reg <= presc_reg + 3'h1;
  end

  assign cap1_edge = ctrl_one_reg[`TMR_CAP_EDGE1_BIT] ? pin_rise[0]
                                                      : pin_fall[0];
  assign cap2_edge = ctrl_two_reg[`TMR_CAP_EDGE2_BIT] ? pin_rise[1]
                                                      : pin_fall[1];

  // Matches are taken on the tick that brings the count to the value
  assign cnt_inc  = cnt_reg + 16'h0001;
  assign cmp1_hit = tick & (cnt_inc == cmp1_reg);
  assign cmp2_hit = tick & (cnt_inc == cmp2_reg);
  assign ovf_hit  = tick & (cnt_reg == `TMR_CNT_MAX);

  // ===================================================================
  // Counter
  always_comb begin
    cnt_next = cnt_reg;
    if (cnt_wr) begin
      cnt_next = `TMR_CNT_RST;
    end else if (pwm_on && cmp2_hit) begin
      cnt_next = `TMR_CNT_RST;
    end else if (single_on && cap1_edge) begin
      cnt_next = `TMR_CNT_RST;
    end else if (tick) begin
      cnt_next = cnt_inc;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) cnt_reg <= `TMR_CNT_RST;
    else        cnt_reg <= cnt_next;
  end

  // ===================================================================
  // Captures; input one is disconnected in PWM mode
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap1_reg <= `TMR_CAP_RST;
      cap2_reg <= `TMR_CAP_RST;
    end else begin
      if (cap1_edge && !pwm_on) cap1_reg <= cnt_reg;
      if (cap2_edge)            cap2_reg <= cnt_reg;
    end
  end

  // ===================================================================
  // Status flags: set wins over the two-step clear
  always_comb begin
    flag_set = 5'h00;
    flag_set[`TMR_FLAG_CAP1] = (cap1_edge & ~pwm_on) | (pwm_on & cmp2_hit);
    flag_set[`TMR_FLAG_CMP1] = cmp1_hit & ~pwm_on & ~single_on;
    flag_set[`TMR_FLAG_CMP2] = cmp2_hit & ~pwm_on;
    flag_set[`TMR_FLAG_OVF]  = ovf_hit;
    flag_set[`TMR_FLAG_CAP2] = cap2_edge;
  end

  // alternate counter never in this set
  always_comb begin
    low_access = 5'h00;
    if (xfer) begin
      low_access[`TMR_FLAG_CAP1] = (paddr == `TMR_CAP1_LO_OFF);
      low_access[`TMR_FLAG_CMP1] = (paddr == `TMR_CMP1_LO_OFF);
      low_access[`TMR_FLAG_OVF]  = (paddr == `TMR_CNT_LO_OFF);
      low_access[`TMR_FLAG_CAP2] = (paddr == `TMR_CAP2_LO_OFF);
      low_access[`TMR_FLAG_CMP2] = (paddr == `TMR_CMP2_LO_OFF);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= 5'h00;
      armed_reg <= 5'h00;
    end else begin
      flags_reg <= flag_set | (flags_reg & ~(armed_reg & low_access));
      if (rd_en && paddr == `TMR_STATUS_OFF) armed_reg <= flags_reg;
      else armed_reg <= armed_reg & ~low_access;
    end
  end

  // ===================================================================
  // Compare outputs; a disabled pin holds its last timer level
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      compare_out_one <= 1'b0;
    end else if (ctrl_two_reg[`TMR_PIN1_EN_BIT]) begin
      if (ctrl_one_reg[`TMR_FORCE_ONE_BIT])
        compare_out_one <= ctrl_one_reg[`TMR_LEVEL_ONE_BIT];
      else if (pwm_on && cmp2_hit)
        compare_out_one <= ctrl_one_reg[`TMR_LEVEL_TWO_BIT];
      else if (single_on && cap1_edge)
        compare_out_one <= ctrl_one_reg[`TMR_LEVEL_TWO_BIT];
      else if (cmp1_hit)
        compare_out_one <= ctrl_one_reg[`TMR_LEVEL_ONE_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      compare_out_two <= 1'b0;
    end else if (ctrl_two_reg[`TMR_PIN2_EN_BIT]) begin
      if (ctrl_one_reg[`TMR_FORCE_TWO_BIT])
        compare_out_two <= ctrl_one_reg[`TMR_LEVEL_TWO_BIT];
      // level two only outside pulse modes
      else if (cmp2_hit && !pwm_on && !single_on)
        compare_out_two <= ctrl_one_reg[`TMR_LEVEL_TWO_BIT];
    end
  end

  assign compare_out_one_oe = ctrl_two_reg[`TMR_PIN1_EN_BIT];
  assign compare_out_two_oe = ctrl_two_reg[`TMR_PIN2_EN_BIT];

  // ===================================================================
  // Interrupt request
  // merged request
  assign irq_pending = ~sys_ctrl_reg[`TMR_GLOBAL_MASK_BIT] & (
    (ctrl_one_reg[`TMR_CAP_IRQ_EN_BIT] &
      (flags_reg[`TMR_FLAG_CAP1] | flags_reg[`TMR_FLAG_CAP2])) |
    (ctrl_one_reg[`TMR_CMP_IRQ_EN_BIT] &
      (flags_reg[`TMR_FLAG_CMP1] | flags_reg[`TMR_FLAG_CMP2])) |
    (ctrl_one_reg[`TMR_OVF_IRQ_EN_BIT] & flags_reg[`TMR_FLAG_OVF]));

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) timer_irq <= 1'b0;
    else        timer_irq <= irq_pending;
  end

  // ===================================================================
  // APB register writes
  assign cnt_wr = wr_en && (paddr == `TMR_CNT_LO_OFF ||
                            paddr == `TMR_ACNT_LO_OFF);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_one_reg <= `TMR_CTRL_RST;
      ctrl_two_reg <= `TMR_CTRL_RST;
      sys_ctrl_reg <= `TMR_SYS_CTRL_RST;
      cmp1_reg     <= `TMR_CMP_RST;
      cmp2_reg     <= `TMR_CMP_RST;
    end else if (wr_en) begin
      case (paddr)
        `TMR_CTRL_ONE_OFF: ctrl_one_reg   <= pwdata[7:0];
        `TMR_CTRL_TWO_OFF: ctrl_two_reg   <= pwdata[7:0];
        `TMR_SYS_CTRL_OFF: sys_ctrl_reg   <= {6'h00, pwdata[1:0]};
        `TMR_CMP1_HI_OFF:  cmp1_reg[15:8] <= pwdata[7:0];
        `TMR_CMP1_LO_OFF:  cmp1_reg[7:0]  <= pwdata[7:0];
        `TMR_CMP2_HI_OFF:  cmp2_reg[15:8] <= pwdata[7:0];
        `TMR_CMP2_LO_OFF:  cmp2_reg[7:0]  <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ===================================================================
  // APB read mux and answer
  always_comb begin
    rd_mux   = 32'h0000_0000;
    addr_hit = 1'b1;
    case (paddr)
      `TMR_CTRL_ONE_OFF: rd_mux[7:0] = ctrl_one_reg;
      `TMR_CTRL_TWO_OFF: rd_mux[7:0] = ctrl_two_reg;
      `TMR_STATUS_OFF:   rd_mux[7:0] = {flags_reg, 3'h0};
      `TMR_CAP1_HI_OFF:  rd_mux[7:0] = cap1_reg[15:8];
      `TMR_CAP1_LO_OFF:  rd_mux[7:0] = cap1_reg[7:0];
      `TMR_CMP1_HI_OFF:  rd_mux[7:0] = cmp1_reg[15:8];
      `TMR_CMP1_LO_OFF:  rd_mux[7:0] = cmp1_reg[7:0];
      `TMR_CMP2_HI_OFF:  rd_mux[7:0] = cmp2_reg[15:8];
      `TMR_CMP2_LO_OFF:  rd_mux[7:0] = cmp2_reg[7:0];
      `TMR_CNT_HI_OFF:   rd_mux[7:0] = cnt_reg[15:8];
      `TMR_CNT_LO_OFF:   rd_mux[7:0] = cnt_reg[7:0];
      `TMR_ACNT_HI_OFF:  rd_mux[7:0] = cnt_reg[15:8];
      `TMR_ACNT_LO_OFF:  rd_mux[7:0] = cnt_reg[7:0];
      `TMR_CAP2_HI_OFF:  rd_mux[7:0] = cap2_reg[15:8];
      `TMR_CAP2_LO_OFF:  rd_mux[7:0] = cap2_reg[7:0];
      `TMR_SYS_CTRL_OFF: rd_mux[7:0] = sys_ctrl_reg;
      default:           addr_hit    = 1'b0;
    endcase
  end

  // Data is sampled one cycle ahead of the completing edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_hit;
      if (psel && penable && !pready && !pwrite) prdata <= rd_mux;
    end
  end

  // ===================================================================
  // Checks
  sequence s_pwm_end;
    pwm_on && cmp2_hit && !cnt_wr;
  endsequence

  a_irq_tracks_flags: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    irq_pending |=> timer_irq)
    else $error("irq not raised for enabled pending flag");

  a_irq_masked_low: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    sys_ctrl_reg[`TMR_GLOBAL_MASK_BIT] |=> !timer_irq)
    else $error("irq raised while globally masked");

  a_pwm_no_compare: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (pwm_on && !flags_reg[`TMR_FLAG_CMP1]) |=> !flags_reg[`TMR_FLAG_CMP1])
    else $error("compare flag one set in PWM mode");

  a_pwm_reload: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_pwm_end |=> (cnt_reg == `TMR_CNT_RST) && flags_reg[`TMR_FLAG_CAP1])
    else $error("PWM period end did not reload counter");

  a_force_one: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (ctrl_two_reg[`TMR_PIN1_EN_BIT] && ctrl_one_reg[`TMR_FORCE_ONE_BIT])
    |=> compare_out_one == $past(ctrl_one_reg[`TMR_LEVEL_ONE_BIT]))
    else $error("forced level one not on output one");

  a_force_two: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (ctrl_two_reg[`TMR_PIN2_EN_BIT] && ctrl_one_reg[`TMR_FORCE_TWO_BIT])
    |=> compare_out_two == $past(ctrl_one_reg[`TMR_LEVEL_TWO_BIT]))
    else $error("forced level two not on output two");

  a_overflow_flag: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ovf_hit |=> flags_reg[`TMR_FLAG_OVF] && cnt_reg != `TMR_CNT_MAX)
    else $error("wrap did not set overflow flag");

  a_capture_two: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    cap2_edge |=> flags_reg[`TMR_FLAG_CAP2] && cap2_reg == $past(cnt_reg))
    else $error("capture two missed value or flag");

  a_ext_clock_stop: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_sel == tmr_pkg::TMR_CLK_EXT && !sys_ctrl_reg[`TMR_EXT_AVAIL_BIT]
     && !cnt_wr && !pwm_on && !single_on) |=> $stable(cnt_reg))
    else $error("counter moved with no external pin");

  a_div8_rate: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_sel == tmr_pkg::TMR_CLK_DIV8 && tick) |=> !tick [*7])
    else $error("divide by eight ticked too often");

endmodule // tmr_timer

`default_nettype wire

// >>> design/tmr_defines.svh
// Register offsets, field positions, reset values and timing counts
// for the 16-bit capture/compare timer. Definitions only.
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

// =====================================================================
// Register byte offsets on the APB bus
`define TMR_CTRL_ONE_OFF    8'h00
`define TMR_CTRL_TWO_OFF    8'h04
`define TMR_STATUS_OFF      8'h08
`define TMR_CAP1_HI_OFF     8'h0C
`define TMR_CAP1_LO_OFF     8'h10
`define TMR_CMP1_HI_OFF     8'h14
`define TMR_CMP1_LO_OFF     8'h18
`define TMR_CMP2_HI_OFF     8'h1C
`define TMR_CMP2_LO_OFF     8'h20
`define TMR_CNT_HI_OFF      8'h24
`define TMR_CNT_LO_OFF      8'h28
`define TMR_ACNT_HI_OFF     8'h2C
`define TMR_ACNT_LO_OFF     8'h30
`define TMR_CAP2_HI_OFF     8'h34
`define TMR_CAP2_LO_OFF     8'h38
`define TMR_SYS_CTRL_OFF    8'h3C

// =====================================================================
// Control register one fields
`define TMR_CAP_IRQ_EN_BIT  7
`define TMR_CMP_IRQ_EN_BIT  6
`define TMR_OVF_IRQ_EN_BIT  5
`define TMR_FORCE_TWO_BIT   4
`define TMR_FORCE_ONE_BIT   3
`define TMR_LEVEL_TWO_BIT   2
`define TMR_CAP_EDGE1_BIT   1
`define TMR_LEVEL_ONE_BIT   0

// Control register two fields
`define TMR_PIN1_EN_BIT     7
`define TMR_PIN2_EN_BIT     6
`define TMR_SINGLE_BIT      5
`define TMR_PWM_BIT         4
`define TMR_CLK_SEL_MSB     3
`define TMR_CLK_SEL_LSB     2
`define TMR_CAP_EDGE2_BIT   1
`define TMR_EXT_EDGE_BIT    0

// Status flag positions (status bits 7..3)
`define TMR_STATUS_LSB      3
`define TMR_FLAG_CAP1       4
`define TMR_FLAG_CMP1       3
`define TMR_FLAG_OVF        2
`define TMR_FLAG_CAP2       1
`define TMR_FLAG_CMP2       0

// System control fields
`define TMR_GLOBAL_MASK_BIT 0
`define TMR_EXT_AVAIL_BIT   1

// =====================================================================
// Reset values
`define TMR_CTRL_RST        8'h00
`define TMR_SYS_CTRL_RST    8'h03
`define TMR_CMP_RST         16'h8000
`define TMR_CNT_RST         16'hFFFC
`define TMR_CNT_MAX         16'hFFFF
`define TMR_CAP_RST         16'h0000

// Prescaler terminal counts
`define TMR_DIV2_LAST       3'h1
`define TMR_DIV4_LAST       3'h3
`define TMR_DIV8_LAST       3'h7

`endif

// >>> design/tmr_pkg.sv
// Types shared by the capture/compare timer.
// Assumes tmr_defines.svh supplies all numeric constants.
package tmr_pkg;
  typedef enum logic [1:0] {
    TMR_CLK_DIV4,
    TMR_CLK_DIV2,
    TMR_CLK_DIV8,
    TMR_CLK_EXT
  } tmr_clk_sel_t;
endpackage

// >>> test/tmr_pin_model.sv
// Far-side model: capture input pins and the external clock pin.
// Assumes its tasks are called from one bench process on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_model (
  // Clock
  input  wire logic sys_clk,
  // Pins towards the timer
  output var  logic capture_in_one,
  output var  logic capture_in_two,
  output var  logic ext_clock_pin
);
  initial begin
    capture_in_one = 1'b0;
    capture_in_two = 1'b0;
    ext_clock_pin  = 1'b0;
  end
  // Held long enough to cross the two-flop input synchronisers
  task automatic set_cap(input int which, input logic lvl);
    @(posedge sys_clk);
    if (which == 1) capture_in_one <= lvl;
    else capture_in_two <= lvl;
    repeat (6) @(posedge sys_clk);
  endtask
  // Clock stands still between bursts, so no stray ticks
  task automatic ext_burst(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      ext_clock_pin <= 1'b1;
      repeat (6) @(posedge sys_clk);
      ext_clock_pin <= 1'b0;
      repeat (5) @(posedge sys_clk);
    end
  endtask
endmodule // tmr_pin_model
`default_nettype wire

// >>> test/test_timer16_control_status_irq.sv
// Self-checking bench for the timer: APB master, pin model, verdict.
// Assumes the design's one-wait-state APB slave and 2-flop pin sync.
`include "tmr_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module test_timer16_control_status_irq;
  logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, c;
  logic [31:0] pwdata, prdata;
  logic cin1, cin2, ext, out1, oe1, out2, oe2, irq, p1;
  logic [16:0] exp_q[$];
  logic [16:0] ent;
  int n_mismatch, n_compared, n;
  tmr_timer uut (.sys_clk(sys_clk), .resetn(resetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_in_one(cin1), .capture_in_two(cin2), .ext_clock_pin(ext),
    .compare_out_one(out1), .compare_out_one_oe(oe1),
    .compare_out_two(out2), .compare_out_two_oe(oe2), .timer_irq(irq));
  tmr_pin_model pins (.sys_clk(sys_clk), .capture_in_one(cin1),
    .capture_in_two(cin2), .ext_clock_pin(ext));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==================================================================
  // APB master; every transfer notes {error, mask, data} for the watcher
  task automatic apb(input logic [7:0] a, input logic wr, input logic [7:0] d,
                     input logic [7:0] m, input logic [7:0] e, input logic er);
    int i;
    exp_q.push_back({er, m, e});
    @(posedge sys_clk);
    paddr <= a;
    pwrite <= wr;
    pwdata <= {24'h000000, d};
    psel <= 1'b1;
    @(posedge sys_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      n_mismatch++;
      give_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b1, d, 8'h00, 8'h00, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    apb(a, 1'b0, 8'h00, m, e, 1'b0);
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  // ==================================================================
  // Watcher: oldest note against each completed transfer
  always @(posedge sys_clk) begin
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
      ent = exp_q.pop_front();
      check({31'h0, pslverr}, {31'h0, ent[16]});
      check(prdata & {24'hFFFFFF, ent[15:8]}, {24'h0, ent[7:0] & ent[15:8]});
    end
  end
  // ==================================================================
  initial begin
    resetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    n_mismatch = 0;
    n_compared = 0;
    c = 8'($urandom(59996));
    idle(16);
    resetn <= 1'b1;
    idle(3);
    rd(`TMR_STATUS_OFF, 8'hFF, 8'h00);
    rd(`TMR_CTRL_ONE_OFF, 8'hFF, 8'h00);
    rd(`TMR_CTRL_TWO_OFF, 8'hFF, 8'h00);
    rd(`TMR_SYS_CTRL_OFF, 8'hFF, 8'h03);
    apb(8'h40, 1'b0, 8'h00, 8'hFF, 8'h00, 1'b1);
    c = 8'($urandom) & 8'hE7;
    wr(`TMR_CTRL_ONE_OFF, c);
    rd(`TMR_CTRL_ONE_OFF, 8'hFF, c);
    // Overflow flag gating, alternate counter read that keeps it, counter low clear
    wr(`TMR_CTRL_ONE_OFF, 8'h20);
    idle(4);
    check({31'h0, irq}, 32'h0); // masked globally
    rd(`TMR_STATUS_OFF, 8'h20, 8'h20); // wrap seen
    wr(`TMR_SYS_CTRL_OFF, 8'h02);
    idle(4);
    check({31'h0, irq}, 32'h1); // enabled flag
    rd(`TMR_STATUS_OFF, 8'h20, 8'h20);
    rd(`TMR_ACNT_LO_OFF, 8'h00, 8'h00);
    idle(3);
    check({31'h0, irq}, 32'h1); // alternate keeps flag
    rd(`TMR_STATUS_OFF, 8'h20, 8'h20);
    rd(`TMR_CNT_LO_OFF, 8'h00, 8'h00);
    idle(3);
    check({31'h0, irq}, 32'h0); // drops when cleared
    // Capture edges on both inputs
    wr(`TMR_CTRL_TWO_OFF, 8'h02);
    wr(`TMR_CTRL_ONE_OFF, 8'h80);
    pins.set_cap(2, 1'b1);
    rd(`TMR_STATUS_OFF, 8'h10, 8'h10); // rising capture
    pins.set_cap(1, 1'b1);
    rd(`TMR_STATUS_OFF, 8'h80, 8'h00); // wrong edge ignored
    check({31'h0, irq}, 32'h1); // capture irq
    pins.set_cap(1, 1'b0);
    rd(`TMR_STATUS_OFF, 8'h80, 8'h80); // falling capture
    rd(`TMR_CAP1_LO_OFF, 8'h00, 8'h00);
    rd(`TMR_CAP2_LO_OFF, 8'h00, 8'h00);
    rd(`TMR_STATUS_OFF, 8'h90, 8'h00); // both cleared
    // Compare one with pin disabled, then enabled
    c = 8'h10 + (8'($urandom) & 8'h0F);
    wr(`TMR_CMP1_HI_OFF, 8'h00);
    wr(`TMR_CMP1_LO_OFF, c);
    wr(`TMR_CTRL_ONE_OFF, 8'h41);
    for (n = 0; n < 2; n++) begin
      wr(`TMR_CTRL_TWO_OFF, n ? 8'h84 : 8'h04);
      wr(`TMR_CNT_LO_OFF, 8'h00);
      idle(80);
      check({31'h0, oe1}, n); // pin handed over
      check({31'h0, out1}, n); // level one on match
      check({31'h0, irq}, 32'h1); // compare irq
      rd(`TMR_STATUS_OFF, 8'h40, 8'h40); // flag set
      rd(`TMR_CMP1_LO_OFF, 8'hFF, c);
      rd(`TMR_STATUS_OFF, 8'h40, 8'h00); // flag cleared
    end
    // Forced levels
    wr(`TMR_CTRL_TWO_OFF, 8'hC4);
    wr(`TMR_CTRL_ONE_OFF, 8'h1C);
    idle(4);
    check({30'h0, out1, out2}, 32'h1); // forced levels
    wr(`TMR_CTRL_ONE_OFF, 8'h19);
    idle(4);
    check({29'h0, oe2, out1, out2}, 32'h6); // swapped
    // External clock, both edges, divide by eight, then pin absent
    wr(`TMR_CTRL_ONE_OFF, 8'h00);
    for (n = 0; n < 4; n++) begin
      wr(`TMR_SYS_CTRL_OFF, n == 3 ? 8'h00 : 8'h02);
      wr(`TMR_CTRL_TWO_OFF, n == 1 ? 8'h0C : (n == 2 ? 8'h08 : 8'h0D));
      wr(`TMR_CNT_LO_OFF, 8'h00);
      pins.ext_burst(3);
      // Divide by eight: 38 clocks give four or five ticks
      rd(`TMR_CNT_LO_OFF, n == 2 ? 8'hFE : 8'hFF,
         n == 3 ? 8'hFC : (n == 2 ? 8'h00 : 8'hFF));
    end
    // One-pulse alone: input edge starts the pulse, compare one ends it
    wr(`TMR_CMP1_LO_OFF, 8'h08);
    wr(`TMR_CTRL_ONE_OFF, 8'h06);
    wr(`TMR_CTRL_TWO_OFF, 8'hA4);
    idle(30);
    pins.set_cap(1, 1'b1);
    check({31'h0, out1}, 32'h1); // pulse started
    idle(40);
    check({31'h0, out1}, 32'h0); // pulse ended
    rd(`TMR_STATUS_OFF, 8'hC0, 8'h80); // trigger flag only
    rd(`TMR_CAP1_LO_OFF, 8'h00, 8'h00);
    wr(`TMR_CTRL_TWO_OFF, 8'h0C);
    wr(`TMR_CNT_LO_OFF, 8'h00);
    // PWM together with one-pulse select
    wr(`TMR_CMP2_HI_OFF, 8'h00);
    wr(`TMR_CMP2_LO_OFF, 8'h10);
    wr(`TMR_CMP1_LO_OFF, 8'h08);
    wr(`TMR_CTRL_ONE_OFF, 8'h04);
    wr(`TMR_CTRL_TWO_OFF, 8'hB4);
    idle(40);
    n = 0;
    p1 = out1;
    repeat (200) begin
      @(posedge sys_clk);
      if (out1 === 1'b1 && p1 === 1'b0) n++;
      p1 = out1;
    end
    check({31'h0, n >= 4 && n <= 5}, 32'h1); // periodic
    rd(`TMR_STATUS_OFF, 8'hC8, 8'h80); // period flag only
    give_verdict();
  end
endmodule // test_timer16_control_status_irq
`default_nettype wire
